// ===== core/adctd_top.sv
// Purpose: Touchscreen drive, register map, result FIFO, freeze and wake
// Assumes: Conversion engine supplies a done pulse with data on i_clk
// Notes:   Pin-side inputs are double synchronised
`default_nettype none
module adctd_top #(
   parameter int DATA_W = 12
) (
   input  wire logic                        i_clk,
   input  wire logic                        i_rst,
   input  wire logic                        i_ce,
   input  wire logic [23:0]                 i_addr,
   input  wire logic                        i_rd,
   input  wire logic                        i_wr,
   input  wire logic [15:0]                 i_wdata,
   output logic      [15:0]                 o_rdata,
   input  wire logic                        i_freeze,
   input  wire logic                        i_conv_done,
   input  wire logic [DATA_W-1:0]           i_conv_data,
   input  wire logic                        i_pen_raw,
   output var        adctd_pkg::adctd_drive_s o_drive,
   output var        adctd_pkg::adctd_ref_s   o_ref,
   output logic                             o_conv_clk_aux,
   output logic                             o_converter_enable,
   output logic                             o_start_pulse,
   output logic      [15:0]                 o_conv_control,
   output logic      [15:0]                 o_start_delay,
   output logic                             o_converter_interrupt,
   output logic                             o_converter_wake_input
);
   import adctd_pkg::*;

   logic [15:0] global_config_reg;
   logic [15:0] aux_config_reg;
   logic [15:0] conv_control_reg;
   logic [15:0] start_delay_reg;
   logic [DATA_W-1:0] fifo_mem_reg [FIFO_DEPTH];
   logic [1:0]  rd_ptr_reg;
   logic [1:0]  wr_ptr_reg;
   logic [2:0]  count_reg;
   logic        overrun_reg;
   logic        unload_gap_reg;
   logic [1:0]  pen_sync_reg;
   logic [1:0]  frz_sync_reg;
   logic        primed_reg;
   logic        converting_reg;
   adctd_drive_s drive_next;
   adctd_ref_s   ref_next;

   function automatic logic hit(input logic [23:0] a, input logic [23:0] r);
      return a == r;
   endfunction : hit

   wire logic en_ok    = global_config_reg[GC_CLKEN];
   wire logic wr_gc    = i_ce && i_wr && hit(i_addr, ADDR_GLOBAL_CONFIG); // see (RULE14)
   wire logic rd_res   = i_ce && i_rd && hit(i_addr, ADDR_CONV_RESULT);
   wire logic frozen   = frz_sync_reg[1];
   wire logic unload   = rd_res && !frozen && (count_reg != 3'd0); // see (RULE8)
   wire logic load     = i_ce && i_conv_done && en_ok; // see (RULE9)
   wire logic full     = count_reg == 3'(FIFO_DEPTH);
   wire logic pen_det  = pen_sync_reg[1] && o_drive.pen_det_en;
   wire logic not_empty = count_reg != 3'd0;
   // Result waiting, no result read in the last two cycles
   wire logic fifo_ready = not_empty && !rd_res && !unload_gap_reg;

   adctd_drive_dec u_dec (
      .i_touch (wr_gc ? i_wdata[GC_TOUCH_LO+:3] : global_config_reg[GC_TOUCH_LO+:3]),
      .i_pref  (global_config_reg[GC_PREF_LO+:2]),
      .i_nref  (global_config_reg[GC_NREF_LO+:2]),
      .o_drive (drive_next),
      .o_ref   (ref_next)
   );

   // Input synchronisers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pen_sync_reg <= 2'b00;
         frz_sync_reg <= 2'b00;
      end else if (i_ce) begin
         pen_sync_reg <= {pen_sync_reg[0], i_pen_raw};
         frz_sync_reg <= {frz_sync_reg[0], i_freeze};
      end
   end

   // Configuration registers
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         global_config_reg <= RESET_VALUE;
         aux_config_reg    <= RESET_VALUE;
         conv_control_reg  <= RESET_VALUE;
         start_delay_reg   <= RESET_VALUE;
      end else if (i_ce && i_wr) begin
         if (hit(i_addr, ADDR_GLOBAL_CONFIG)) begin
            global_config_reg <= i_wdata;
         end
         if (hit(i_addr, ADDR_AUX_CONFIG)) begin
            aux_config_reg <= i_wdata & AC_WR_MASK;
         end
         if (hit(i_addr, ADDR_CONV_CONTROL) && en_ok) begin
            conv_control_reg <= i_wdata;
         end
         if (hit(i_addr, ADDR_START_DELAY) && en_ok) begin
            start_delay_reg <= i_wdata;
         end
      end
   end

   // Plate drivers updated only by a config write; references follow the register each cycle
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_drive <= '0; // see (RULE18)
         o_ref   <= '0;
      end else if (i_ce) begin
         if (wr_gc) begin
            o_drive <= drive_next; // see (RULE4)
         end
         o_ref <= ref_next;
      end
   end

   // Prime and conversion status
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         primed_reg     <= 1'b0;
         converting_reg <= 1'b0;
         o_start_pulse  <= 1'b0;
      end else if (i_ce) begin
         o_start_pulse <= i_wr && hit(i_addr, ADDR_START_CONV) && en_ok;
         if (!en_ok || i_conv_done) begin
            primed_reg     <= 1'b0;
            converting_reg <= 1'b0;
         end else if (i_wr && hit(i_addr, ADDR_START_CONV)) begin
            primed_reg     <= 1'b1;
            converting_reg <= 1'b1;
         end
      end
   end

   // Result FIFO on system clock
   always_ff @(posedge i_clk or posedge i_rst) begin // see (RULE11)
      if (i_rst) begin
         rd_ptr_reg  <= 2'd0;
         wr_ptr_reg  <= 2'd0;
         count_reg   <= 3'd0;
         overrun_reg <= 1'b0;
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            fifo_mem_reg[i] <= '0;
         end
      end else if (i_ce) begin
         if (load && !full) begin
            fifo_mem_reg[wr_ptr_reg] <= i_conv_data;
            wr_ptr_reg <= wr_ptr_reg + 2'd1;
         end
         if (unload) begin
            rd_ptr_reg <= rd_ptr_reg + 2'd1;
         end
         count_reg <= count_reg + 3'((load && !full) ? 1 : 0) - 3'(unload ? 1 : 0);
         if (load && full && !unload) begin
            overrun_reg <= 1'b1;
         end else if (unload) begin
            overrun_reg <= 1'b0;
         end
      end
   end

   // Interrupt, and wake unless pen detected, low for two cycles from a result read
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         unload_gap_reg         <= 1'b0;
         o_converter_interrupt  <= 1'b0;
         o_converter_wake_input <= 1'b0;
      end else if (i_ce) begin
         unload_gap_reg         <= rd_res;
         o_converter_interrupt  <= fifo_ready && global_config_reg[GC_INTEN]; // see (RULE9)
         o_converter_wake_input <= fifo_ready || pen_det; // see (RULE12)
      end
   end

   // Registered copies of configuration
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_conv_clk_aux     <= 1'b0;
         o_converter_enable <= 1'b0;
         o_conv_control     <= '0;
         o_start_delay      <= '0;
      end else if (i_ce) begin
         o_conv_clk_aux     <= aux_config_reg[AC_CLKSEL]; // see (RULE10)
         o_converter_enable <= en_ok;
         o_conv_control     <= conv_control_reg;
         o_start_delay      <= start_delay_reg;
      end
   end

   // Read data, zero outside a read
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= '0;
      end else if (i_ce) begin
         o_rdata <= '0;
         if (i_rd) begin
            case (i_addr)
               ADDR_GLOBAL_CONFIG: o_rdata <= global_config_reg;
               ADDR_AUX_CONFIG: begin
                  o_rdata <= aux_config_reg;
                  o_rdata[AC_PRM]  <= primed_reg;
                  o_rdata[AC_TRG]  <= converting_reg;
                  o_rdata[AC_CNVT] <= converting_reg;
               end
               ADDR_CONV_CONTROL: o_rdata <= conv_control_reg;
               ADDR_START_DELAY:  o_rdata <= start_delay_reg;
               ADDR_CONV_RESULT: begin
                  o_rdata[DATA_W-1:0]  <= fifo_mem_reg[rd_ptr_reg];
                  o_rdata[RS_DONE]     <= not_empty;
                  o_rdata[RS_OVERRUN]  <= overrun_reg;
                  o_rdata[RS_PEN_DOWN] <= pen_det;
               end
               default: o_rdata <= '0;
            endcase
         end
      end
   end
endmodule : adctd_top
`default_nettype wire

// ===== inc/adctd_pkg.sv
// Purpose: Constants and types for the touchscreen drive control block
// Assumes: 16-bit CPU register port, word registers at even byte addresses
// Notes:   Overview list below
//
// Overview of operation
// (RULE1) Code 010b: x_plate_pos high, x_plate_neg low, Y terminals undriven.
// (RULE2) Code 001b: y_plate_pos high, y_plate_neg low, X terminals undriven.
// (RULE3) Code 100b: y_plate_pos high, x_plate_neg low for contact resistance.
// (RULE4) Pull-high only on positive terminals, pull-low only on negative ones.
// (RULE5) Positive reference can connect internally to y_plate_pos.
// (RULE6) Negative reference can connect internally to y_plate_neg.
// (RULE7) Software takes two conversions per coordinate and averages them.
// (RULE8) Halt input suppresses unload on result register read.
// (RULE9) During halt, results still load into FIFO and interrupt may rise.
// (RULE10) Auxiliary clock may be chosen as conversion clock source.
// (RULE11) Result path advances only on system clock edges.
// (RULE12) Completed conversion asserts wake output to the wake unit.
// (RULE13) Software disables converter before low power when unneeded.
// (RULE14) Six 16-bit registers at even addresses FF F3C0h to FF F3CAh.
// (RULE15) Code 101b: weak pull x_plate_pos, y_plate_neg low, pen detector on.
// (RULE16) Positive reference codes: 00 supply, 01 pin, 10 input0, 11 input1.
// (RULE17) Negative reference codes: 00 ground, 10 input2, 11 input3, 01 reserved.
// (RULE18) Reset and reserved codes leave all plates undriven; changes only on write.
`default_nettype none
package adctd_pkg;
   localparam logic [23:0] ADDR_GLOBAL_CONFIG = 24'hfff3c0;
   localparam logic [23:0] ADDR_AUX_CONFIG    = 24'hfff3c2;
   localparam logic [23:0] ADDR_CONV_CONTROL  = 24'hfff3c4;
   localparam logic [23:0] ADDR_START_CONV    = 24'hfff3c6;
   localparam logic [23:0] ADDR_START_DELAY   = 24'hfff3c8;
   localparam logic [23:0] ADDR_CONV_RESULT   = 24'hfff3ca;
   localparam logic [15:0] RESET_VALUE        = 16'h0000;
   // global_config fields
   localparam int GC_CLKEN = 0;
   localparam int GC_DIFF  = 2;
   localparam int GC_TOUCH_LO = 6;
   localparam int GC_PREF_LO  = 9;
   localparam int GC_NREF_LO  = 11;
   localparam int GC_INTEN    = 14;
   // aux_config fields
   localparam int AC_CLKSEL = 0;
   localparam int AC_PRM    = 13;
   localparam int AC_TRG    = 14;
   localparam int AC_CNVT   = 15;
   localparam logic [15:0] AC_WR_MASK = 16'h0007;
   // conversion_result fields
   localparam int RS_DONE     = 15;
   localparam int RS_OVERRUN  = 14;
   localparam int RS_PEN_DOWN = 13;
   localparam int FIFO_DEPTH  = 4;
   typedef enum logic [2:0] {
      TC_NONE     = 3'b000,
      TC_SAMPLE_Y = 3'b001,
      TC_SAMPLE_X = 3'b010,
      TC_SAMPLE_Z1 = 3'b011,
      TC_SAMPLE_Z2 = 3'b100,
      TC_PEN_DET  = 3'b101
   } adctd_touch_e;
   localparam logic [1:0] PREF_AVCC = 2'b00;
   localparam logic [1:0] PREF_PIN  = 2'b01;
   localparam logic [1:0] PREF_IN0  = 2'b10;
   localparam logic [1:0] PREF_IN1  = 2'b11;
   localparam logic [1:0] NREF_AGND = 2'b00;
   localparam logic [1:0] NREF_IN2  = 2'b10;
   localparam logic [1:0] NREF_IN3  = 2'b11;
   // Plate drive: one-hot strengths per terminal
   typedef struct packed {
      logic x_pos_high;
      logic x_pos_weak;
      logic y_pos_high;
      logic x_neg_low;
      logic y_neg_low;
      logic pen_det_en;
   } adctd_drive_s;
   // Reference selection, one-hot per polarity
   typedef struct packed {
      logic pos_avcc;
      logic pos_pin;
      logic pos_in0;
      logic pos_y_plate;
      logic neg_agnd;
      logic neg_in2;
      logic neg_y_plate;
   } adctd_ref_s;
endpackage : adctd_pkg
`default_nettype wire

// ===== core/adctd_drive_dec.sv
// Purpose: Decodes driver and reference codes into one-hot controls
// Assumes: Purely combinational; caller registers the outputs
// Notes:   Reserved codes give no drive
`default_nettype none
module adctd_drive_dec (
   input  wire logic [2:0]                i_touch,
   input  wire logic [1:0]                i_pref,
   input  wire logic [1:0]                i_nref,
   output var        adctd_pkg::adctd_drive_s o_drive,
   output var        adctd_pkg::adctd_ref_s   o_ref
);
   import adctd_pkg::*;
   always_comb begin
      o_drive = '0;
      case (i_touch)
         TC_SAMPLE_X: begin
            o_drive.x_pos_high = 1'b1; // see (RULE1)
            o_drive.x_neg_low  = 1'b1;
         end
         TC_SAMPLE_Y: begin
            o_drive.y_pos_high = 1'b1; // see (RULE2)
            o_drive.y_neg_low  = 1'b1;
         end
         TC_SAMPLE_Z1: begin
            o_drive.x_pos_high = 1'b1;
            o_drive.y_neg_low  = 1'b1;
         end
         TC_SAMPLE_Z2: begin
            o_drive.y_pos_high = 1'b1; // see (RULE3)
            o_drive.x_neg_low  = 1'b1;
         end
         TC_PEN_DET: begin
            o_drive.x_pos_weak = 1'b1; // see (RULE15)
            o_drive.y_neg_low  = 1'b1;
            o_drive.pen_det_en = 1'b1;
         end
         default: o_drive = '0; // see (RULE18)
      endcase
   end
   always_comb begin
      o_ref = '0;
      case (i_pref) // see (RULE16)
         PREF_AVCC: o_ref.pos_avcc    = 1'b1;
         PREF_PIN:  o_ref.pos_pin     = 1'b1;
         PREF_IN0:  o_ref.pos_in0     = 1'b1;
         PREF_IN1:  o_ref.pos_y_plate = 1'b1; // see (RULE5)
         default:   o_ref.pos_avcc    = 1'b1;
      endcase
      case (i_nref) // see (RULE17)
         NREF_IN2: o_ref.neg_in2     = 1'b1;
         NREF_IN3: o_ref.neg_y_plate = 1'b1; // see (RULE6)
         default:  o_ref.neg_agnd    = 1'b1;
      endcase
   end
endmodule : adctd_drive_dec
`default_nettype wire

// ===== sim/adctd_props.sv
// Purpose: Port checker for adctd_top
// Assumes: One clock, asynchronous reset
// Notes:   Bound from the testbench file
`default_nettype none
module adctd_props #(
   parameter int DATA_W = 12
) (
   input wire logic                    i_clk,
   input wire logic                    i_rst,
   input wire logic                    i_ce,
   input wire logic [23:0]             i_addr,
   input wire logic                    i_rd,
   input wire logic                    i_wr,
   input wire logic [15:0]             i_wdata,
   input wire logic [15:0]             o_rdata,
   input wire logic                    i_freeze,
   input wire logic                    i_conv_done,
   input wire logic [DATA_W-1:0]       i_conv_data,
   input wire logic                    i_pen_raw,
   input wire adctd_pkg::adctd_drive_s o_drive,
   input wire adctd_pkg::adctd_ref_s   o_ref,
   input wire logic                    o_conv_clk_aux,
   input wire logic                    o_converter_enable,
   input wire logic                    o_start_pulse,
   input wire logic [15:0]             o_conv_control,
   input wire logic [15:0]             o_start_delay,
   input wire logic                    o_converter_interrupt,
   input wire logic                    o_converter_wake_input
);
   import adctd_pkg::*;
   wire logic gc_wr = i_wr && i_ce && i_addr == ADDR_GLOBAL_CONFIG;
   wire logic rs_rd = i_rd && i_ce && i_addr == ADDR_CONV_RESULT;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   x_sample_a: assert property (gc_wr && i_wdata[8:6] == 3'h2 |=> o_drive == 6'h24)
      else $error("x sample drive wrong");
   y_sample_a: assert property (gc_wr && i_wdata[8:6] == 3'h1 |=> o_drive == 6'h0a)
      else $error("y sample drive wrong");
   z_sample_a: assert property (gc_wr && i_wdata[8:6] == 3'h4 |=> o_drive == 6'h0c)
      else $error("force drive wrong");
   pen_drive_a: assert property (gc_wr && i_wdata[8:6] == 3'h5 |=> o_drive == 6'h13)
      else $error("pen detect drive wrong");
   drive_hold_a: assert property (!gc_wr |=> $stable(o_drive))
      else $error("drive changed without write");
   pos_plate_a: assert property (gc_wr && i_wdata[10:9] == 2'h3
      |-> ##2 o_ref.pos_y_plate) else $error("positive reference not on plate");
   neg_plate_a: assert property (gc_wr && i_wdata[12:11] == 2'h3
      |-> ##2 o_ref.neg_y_plate) else $error("negative reference not on plate");
   aux_clock_a: assert property (i_wr && i_ce && i_addr == ADDR_AUX_CONFIG
      |-> ##2 o_conv_clk_aux == $past(i_wdata[0], 2)) else $error("clock select wrong");
   wake_done_a: assert property (i_conv_done && !i_rd
      |-> ##[1:3] o_converter_wake_input) else $error("no wake after done");
   irq_gap_a: assert property (rs_rd && !i_freeze |=> !o_converter_interrupt [*2])
      else $error("interrupt not dropped on read");
   rdata_idle_a: assert property (i_ce && !i_rd |=> o_rdata == 16'h0000)
      else $error("read data without read");
   start_cause_a: assert property (o_start_pulse |-> $past(i_wr && i_ce
      && i_addr == ADDR_START_CONV)) else $error("start without write");
   cover property (gc_wr && i_wdata[8:6] == 3'h5);
   cover property (o_start_pulse ##[1:40] i_conv_done);
   cover property (rs_rd && i_freeze);
endmodule : adctd_props
`default_nettype wire

// ===== sim/adctd_plate_model.sv
// Purpose: Plates and conversion engine at the far side
// Assumes: Result is the sample set by the bench
// Notes:   Data shows the inverse outside done
`default_nettype none
module adctd_plate_model #(
   parameter int LAT = 6
) (
   input  wire logic                    i_clk,
   input  wire logic                    i_rst,
   input  wire logic                    i_start,
   input  wire adctd_pkg::adctd_drive_s i_drive,
   input  wire logic [11:0]             i_sample,
   input  wire logic                    i_touch,
   output logic                         o_done,
   output logic [11:0]                  o_data,
   output logic                         o_pen_raw
);
   import adctd_pkg::*;
   int cnt_reg;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_reg <= 0;
      end else if (i_start) begin
         cnt_reg <= LAT;
      end else if (cnt_reg != 0) begin
         cnt_reg <= cnt_reg - 1;
      end
   end
   assign o_done = cnt_reg == 1;
   assign o_data = o_done ? i_sample : ~i_sample;
   // Contact pulls the weak positive X terminal low
   assign o_pen_raw = i_drive.pen_det_en && i_drive.x_pos_weak && i_touch;
endmodule : adctd_plate_model
`default_nettype wire

// ===== sim/adctd_tb.sv
// Purpose: Self-checking bench for adctd_top
// Assumes: Plate model supplies conversions and contact
// Notes:   Read data checked from a queue by a monitor
`default_nettype none
`define CHK(a, b) check(16'(a), 16'(b))
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import adctd_pkg::*;
   logic         i_clk = 0, i_rst = 1, i_ce = 1, i_rd = 0, i_wr = 0, i_freeze = 0;
   logic         touch = 0, rd_pend = 0, i_conv_done, i_pen_raw, o_conv_clk_aux;
   logic         o_converter_enable, o_start_pulse, o_converter_interrupt, o_converter_wake_input;
   logic [23:0]  i_addr = '0;
   logic [15:0]  i_wdata = '0, o_rdata, o_conv_control, o_start_delay, v;
   logic [15:0]  r [5];
   logic [11:0]  sample = '0, i_conv_data;
   logic [6:0]   ref_exp;
   logic [5:0]   drv_tab [8] = '{6'h00, 6'h0a, 6'h24, 6'h22, 6'h0c, 6'h13, 6'h00, 6'h00};
   logic [15:0]  exp_q [$];
   adctd_drive_s o_drive;
   adctd_ref_s   o_ref;
   int           num_errors = 0, compares = 0, cycles = 0, seed = 63936;
   always #4 i_clk = ~i_clk;
   adctd_top #(.DATA_W(12)) dut (.i_clk, .i_rst, .i_ce, .i_addr, .i_rd, .i_wr, .i_wdata,
      .o_rdata, .i_freeze, .i_conv_done, .i_conv_data, .i_pen_raw, .o_drive, .o_ref,
      .o_conv_clk_aux, .o_converter_enable, .o_start_pulse, .o_conv_control, .o_start_delay,
      .o_converter_interrupt, .o_converter_wake_input);
   adctd_plate_model #(.LAT(6)) plate (.i_clk, .i_rst, .i_start(o_start_pulse),
      .i_drive(o_drive), .i_sample(sample), .i_touch(touch), .o_done(i_conv_done),
      .o_data(i_conv_data), .o_pen_raw(i_pen_raw));
   task automatic check(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask : check
   task automatic print_verdict;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic bus(input logic rd, input logic [23:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_rd <= rd;
      i_wr <= !rd;
      i_addr <= a;
      i_wdata <= d;
      if (rd) exp_q.push_back(d);
      @(posedge i_clk);
      i_rd <= 0;
      i_wr <= 0;
   endtask : bus
   function automatic logic [15:0] gcv(input logic [2:0] t, input logic [1:0] p,
      input logic [1:0] n, input logic ie);
      return {1'b0, ie, 1'b0, n, p, t, 6'h01};
   endfunction : gcv
   task automatic convert(input logic [11:0] d);
      sample <= d;
      bus(1'b0, ADDR_START_CONV, 16'h0000);
      for (int i = 0; i < 40 && i_conv_done !== 1'b1; i++) @(negedge i_clk);
      repeat (3) @(posedge i_clk);
   endtask : convert
   always @(posedge i_clk) begin
      if (rd_pend) begin
         v = exp_q.pop_front();
         `CHK(o_rdata, v);
      end
      rd_pend <= i_rd && i_ce;
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         print_verdict();
      end
   end
   initial begin
      repeat (8) @(posedge i_clk);
      i_rst <= 0;
      bus(1'b1, ADDR_AUX_CONFIG, RESET_VALUE);
      bus(1'b1, 24'hfff3cc, 16'h0000);
      for (int c = 0; c < 8; c++) begin
         bus(1'b0, ADDR_GLOBAL_CONFIG, gcv(3'(c), 2'h0, 2'h0, 1'b0));
         @(negedge i_clk);
         `CHK(o_drive, drv_tab[c]);
         bus(1'b1, ADDR_GLOBAL_CONFIG, gcv(3'(c), 2'h0, 2'h0, 1'b0));
      end
      i_ce <= 0;
      bus(1'b0, ADDR_GLOBAL_CONFIG, gcv(3'h2, 2'h0, 2'h0, 1'b0));
      i_ce <= 1;
      @(negedge i_clk);
      `CHK(o_drive, 6'h00);
      for (int p = 0; p < 4; p++) begin
         for (int n = 0; n < 4; n += 1 + (n == 0)) begin
            bus(1'b0, ADDR_GLOBAL_CONFIG, gcv(3'h0, 2'(p), 2'(n), 1'b0));
            repeat (2) @(negedge i_clk);
            ref_exp = {4'h8 >> p, n == 0 ? 3'h4 : n == 2 ? 3'h2 : 3'h1};
            `CHK(o_ref, ref_exp);
         end
      end
      r[0] = 16'($random(seed));
      r[1] = 16'($random(seed));
      bus(1'b0, ADDR_GLOBAL_CONFIG, 16'h0000);
      bus(1'b0, ADDR_CONV_CONTROL, r[0]);
      bus(1'b1, ADDR_CONV_CONTROL, 16'h0000);
      bus(1'b0, ADDR_GLOBAL_CONFIG, gcv(3'h0, 2'h0, 2'h0, 1'b1));
      bus(1'b0, ADDR_CONV_CONTROL, r[0]);
      bus(1'b0, ADDR_START_DELAY, r[1]);
      bus(1'b1, ADDR_CONV_CONTROL, r[0]);
      bus(1'b1, ADDR_START_DELAY, r[1]);
      `CHK(o_start_delay, r[1]);
      `CHK(o_conv_control, r[0]);
      bus(1'b0, ADDR_AUX_CONFIG, 16'h0001);
      repeat (2) @(negedge i_clk);
      `CHK(o_conv_clk_aux, 1'b1);
      bus(1'b1, ADDR_AUX_CONFIG, 16'h0001);
      bus(1'b0, ADDR_AUX_CONFIG, 16'h0000);
      for (int k = 2; k > 0; k--) begin
         bus(1'b0, ADDR_GLOBAL_CONFIG, gcv(3'(k), 2'h0, 2'h0, 1'b1));
         for (int j = 0; j < 2; j++) begin
            r[j] = 16'($random(seed)) & 16'h0fff;
            convert(r[j][11:0]);
         end
         `CHK(o_converter_interrupt, 1'b1);
         `CHK(o_converter_wake_input, 1'b1);
         for (int j = 0; j < 2; j++) bus(1'b1, ADDR_CONV_RESULT, r[j] | 16'h8000);
         repeat (3) @(negedge i_clk);
         `CHK(o_converter_wake_input, 1'b0);
      end
      for (int j = 0; j < 5; j++) begin
         r[j] = 16'($random(seed)) & 16'h0fff;
         convert(r[j][11:0]);
      end
      for (int j = 0; j < 4; j++) begin
         bus(1'b1, ADDR_CONV_RESULT, r[j] | (j == 0 ? 16'hc000 : 16'h8000));
      end
      i_freeze <= 1;
      convert(r[4][11:0]);
      `CHK(o_converter_interrupt, 1'b1);
      repeat (2) bus(1'b1, ADDR_CONV_RESULT, r[4] | 16'h8000);
      i_freeze <= 0;
      repeat (4) @(posedge i_clk);
      bus(1'b1, ADDR_CONV_RESULT, r[4] | 16'h8000);
      touch <= 1;
      bus(1'b0, ADDR_GLOBAL_CONFIG, gcv(3'h5, 2'h0, 2'h0, 1'b0));
      repeat (4) @(negedge i_clk);
      `CHK(o_converter_wake_input, 1'b1);
      touch <= 0;
      repeat (4) @(negedge i_clk);
      `CHK(o_converter_wake_input, 1'b0);
      bus(1'b0, ADDR_GLOBAL_CONFIG, 16'h0000);
      repeat (2) @(negedge i_clk);
      `CHK(o_converter_enable, 1'b0);
      repeat (4) @(posedge i_clk);
      print_verdict();
   end
endmodule : testbench
bind adctd_top adctd_props #(.DATA_W(DATA_W)) props (.i_clk, .i_rst, .i_ce, .i_addr, .i_rd,
   .i_wr, .i_wdata, .o_rdata, .i_freeze, .i_conv_done, .i_conv_data, .i_pen_raw, .o_drive,
   .o_ref, .o_conv_clk_aux, .o_converter_enable, .o_start_pulse, .o_conv_control,
   .o_start_delay, .o_converter_interrupt, .o_converter_wake_input);
`default_nettype wire
